/* tb.sv */
// Self-checking testbench for the timer prescaler and interrupt flag block.
`timescale 1ns/10ps
`default_nettype none
module tb;
   // ****************
   // Stimulus and design
   // ****************
   logic                     i_clk = 1'b0, i_resetn = 1'b0, gie = 1'b0, run = 1'b0, ce = 1'b1;
   logic                     p8, p16;
   tpi_pkg::tpi_bus_req_t    bus = '0;
   tpi_pkg::tpi_t16_events_t ev = '0;
   logic [2:0]               sel8 = 3'h0, sel16 = 3'h0, wgm = 3'h0, ack = 3'h0, req;
   logic [7:0]               cnt = 8'h00, rdata;
   logic [1:0]               pins;
   logic [12:0]              v;
   int                       err_count = 0, cmp_count = 0, cyc = 0, n8, n16;
   int                       dv [6] = '{0, 1, 8, 64, 256, 1024};
   logic [2:0]               tw [11] = '{0, 1, 1, 2, 3, 5, 7, 4, 6, 0, 0};
   logic [7:0]               tc [11] = '{255, 0, 255, 255, 255, 0, 85, 255, 255, 85, 170};
   logic [7:0]               tf [11] = '{2, 2, 0, 2, 2, 2, 3, 0, 0, 1, 4};
   tpi_top i_tpi_top (.i_clk, .i_resetn, .i_ce(ce), .i_bus(bus), .o_rdata(rdata),
      .i_t8_clock_select_field(sel8), .i_t16_clock_select_field(sel16),
      .i_ext_timer_clock_pins(pins), .i_waveform_mode_field(wgm), .i_t8_count(cnt),
      .i_t8_compare_a_value(8'h55), .i_t8_compare_b_value(8'hAA), .i_t16_events(ev),
      .i_global_irq_en(gie), .i_irq_ack(ack), .o_t8_count_pulse(p8),
      .o_t16_count_pulse(p16), .o_irq_req(req));
   tpi_pin_model i_tpi_pin_model (.i_clk, .i_run(run), .i_half(4'h2), .o_pins(pins));
   // Clock and hang guard.
   initial forever #4 i_clk = ~i_clk;
   always @(posedge i_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         err_count++;
         end_of_test();
      end
   end
   // ****************
   // Tasks
   // ****************
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      if (err_count == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge i_clk);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge i_clk);
      bus <= '0;
   endtask
   task automatic rd(input logic [1:0] a, input logic [7:0] exp);
      @(posedge i_clk);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge i_clk);
      bus <= '0;
      #1;
      check(rdata, exp);
   endtask
   // Lets the 8-bit timer tick on the undivided clock at one count value.
   task automatic run8(input logic [2:0] w, input logic [7:0] c);
      @(posedge i_clk);
      wgm <= w;
      cnt <= c;
      sel8 <= tpi_pkg::CS_DIRECT;
      repeat (3) @(posedge i_clk);
      sel8 <= tpi_pkg::CS_STOPPED;
      repeat (2) @(posedge i_clk);
   endtask
   // ****************
   // Main sequence
   // ****************
   initial
   begin
      repeat (10) @(posedge i_clk);
      i_resetn <= 1'b1;
      rd(2'h0, 8'h00);
      rd(2'h2, 8'h00);
      wr(2'h3, 8'hFF);
      rd(2'h1, 8'h00);
      rd(2'h3, 8'h00);
      wr(2'h1, 8'hFF);
      rd(2'h1, 8'hEF);
      for (int i = 0; i < 11; i++)
      begin
         run8(tw[i], tc[i]);
         rd(2'h0, tf[i]);
         wr(2'h0, 8'h07);
      end
      run8(3'h0, 8'h55);
      run8(3'h0, 8'hAA);
      run8(3'h0, 8'hFF);
      #1;
      check({5'h00, req}, 8'h00);
      @(posedge i_clk) gie <= 1'b1;
      @(posedge i_clk) #1;
      check({5'h00, req}, 8'h07);
      wr(2'h1, 8'hFE);
      #1;
      check({5'h00, req}, 8'h06);
      wr(2'h1, 8'hFF);
      @(posedge i_clk) ack <= 3'h2;
      @(posedge i_clk) ack <= 3'h0;
      #1;
      check({5'h00, req}, 8'h05);
      wr(2'h0, 8'h04);
      rd(2'h0, 8'h01);
      @(posedge i_clk) gie <= 1'b0;
      @(posedge i_clk) #1;
      check({5'h00, req}, 8'h00);
      @(posedge i_clk) ev <= 4'hF;
      @(posedge i_clk) ev <= 4'h0;
      rd(2'h0, 8'hE9);
      wr(2'h0, 8'hE9);
      rd(2'h0, 8'h00);
      for (int s = 0; s < 6; s++)
      begin
         @(posedge i_clk) sel16 <= s[2:0];
         repeat (3) @(posedge i_clk);
         #1;
         n16 = 0;
         repeat (s == 0 ? 16 : 2 * dv[s])
         begin
            n16 += p16;
            @(posedge i_clk) #1;
         end
         check(n16[7:0], s == 0 ? 8'h00 : 8'h02);
      end
      @(posedge i_clk) sel16 <= tpi_pkg::CS_DIV8;
      sel8 <= tpi_pkg::CS_DIV8;
      repeat (20) @(posedge i_clk);
      wr(2'h2, 8'h01);
      #1;
      for (int i = 1; i < 11; i++)
      begin
         v[i] = p8;
         @(posedge i_clk) #1;
      end
      check(v[10:3], 8'h80);
      rd(2'h2, 8'h00);
      @(posedge i_clk) sel8 <= tpi_pkg::CS_EXT_RISE;
      sel16 <= tpi_pkg::CS_EXT_FALL;
      repeat (3) @(posedge i_clk);
      n8 = 0;
      n16 = 0;
      for (int k = 0; k < 40; k++)
      begin
         @(posedge i_clk) run <= (k < 32);
         #1;
         n8 += p8;
         n16 += p16;
      end
      check(n8[7:0], 8'h08);
      check(n16[7:0], 8'h08);
      // A write while the clock enable is low must leave the mask untouched.
      @(posedge i_clk) ce <= 1'b0;
      wr(2'h1, 8'h00);
      @(posedge i_clk) ce <= 1'b1;
      rd(2'h1, 8'hEF);
      end_of_test();
   end
endmodule
`default_nettype wire

/* tpi_assertions.sv */
// Checker for the timer prescaler and interrupt flag block.
`timescale 1ns/10ps
`default_nettype none
// ****************
// Port checks
// ****************
module tpi_assertions
(
   input wire logic                  i_clk,
   input wire logic                  i_resetn,
   input wire tpi_pkg::tpi_bus_req_t i_bus,
   input wire logic [7:0]            o_rdata,
   input wire logic [2:0]            i_t8_clock_select_field,
   input wire logic [2:0]            i_t16_clock_select_field,
   input wire logic [1:0]            i_ext_timer_clock_pins,
   input wire logic                  i_global_irq_en,
   input wire logic [2:0]            i_irq_ack,
   input wire logic                  o_t8_count_pulse,
   input wire logic                  o_t16_count_pulse,
   input wire logic [2:0]            o_irq_req
);
   // One clock domain; every check rests while reset is held.
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);
   AST_REQ_A: assert property (o_irq_req[0] |-> $past(i_global_irq_en))
      else $error("compare A request without global enable");
   AST_REQ_O: assert property (o_irq_req[1] |-> $past(i_global_irq_en))
      else $error("overflow request without global enable");
   AST_REQ_B: assert property (o_irq_req[2] |-> $past(i_global_irq_en))
      else $error("compare B request without global enable");
   AST_RDATA: assert property (o_rdata != 8'h00 |-> $past(i_bus.rd) && !o_rdata[4]
      && $past(i_bus.addr) < tpi_pkg::ADDR_GENERAL_CTRL) else $error("stray read data");
   AST_DIRECT: assert property ($past(i_t8_clock_select_field) == tpi_pkg::CS_DIRECT
      && $past(i_resetn) |-> o_t8_count_pulse) else $error("direct select missed a pulse");
   AST_STOP: assert property ($past(i_t16_clock_select_field) == tpi_pkg::CS_STOPPED
      |-> !o_t16_count_pulse) else $error("pulse while stopped");
   AST_DIV8: assert property (o_t16_count_pulse && $past(i_t16_clock_select_field) == 3'h2
      |=> (!o_t16_count_pulse || $past(i_t16_clock_select_field) != 3'h2) [*7])
      else $error("divide by 8 pulses too close");
   AST_PSR: assert property (i_bus.wr && i_bus.addr == 2'h2 && i_bus.wdata[0]
      && i_t16_clock_select_field == tpi_pkg::CS_DIV8
      |-> ##3 (!o_t16_count_pulse) [*7] ##1 o_t16_count_pulse) else $error("restart timing");
   AST_EXT: assert property ($rose(i_ext_timer_clock_pins[0])
      && i_t8_clock_select_field == tpi_pkg::CS_EXT_RISE |-> ##[1:3] o_t8_count_pulse)
      else $error("pin edge not counted in time");
   AST_ACK: assert property (i_irq_ack[1] && !o_t8_count_pulse |=> !o_irq_req[1])
      else $error("acknowledge did not clear");
   AST_W1C: assert property (i_bus.wr && i_bus.addr == 2'h0 && i_bus.wdata[2]
      && !o_t8_count_pulse |=> !o_irq_req[2]) else $error("write one did not clear");
   AST_REQ_MASK: assert property (i_bus.wr && i_bus.addr == 2'h1
      |=> (o_irq_req & ~$past(i_bus.wdata[2:0])) == 3'h0)
      else $error("request with its enable cleared");
   // Main scenarios reached.
   cover property (o_irq_req == 3'h7);
   cover property (o_t8_count_pulse && i_t8_clock_select_field == tpi_pkg::CS_EXT_RISE);
   cover property (i_irq_ack[1] && o_irq_req[1]);
endmodule
bind tpi_top tpi_assertions i_tpi_assertions (.i_clk, .i_resetn, .i_bus, .o_rdata,
   .i_t8_clock_select_field, .i_t16_clock_select_field, .i_ext_timer_clock_pins,
   .i_global_irq_en, .i_irq_ack, .o_t8_count_pulse, .o_t16_count_pulse, .o_irq_req);
`default_nettype wire

/* tpi_pin_model.sv */
// External clock source that drives both timer clock pins.
`timescale 1ns/10ps
`default_nettype none
// ****************
// Pin source
// ****************
module tpi_pin_model
(
   input  wire logic       i_clk,
   input  wire logic       i_run,
   input  wire logic [3:0] i_half,
   output wire logic [1:0] o_pins
);
   logic [3:0] cnt  = 4'h0;
   logic [1:0] pins = 2'h0;
   assign o_pins = pins;
   // Pins toggle every i_half clocks while running and hold still otherwise.
   always @(posedge i_clk)
   begin
      if (!i_run)
         cnt <= 4'h0;
      else if (cnt == i_half - 4'h1)
      begin
         cnt <= 4'h0;
         pins <= ~pins;
      end
      else
         cnt <= cnt + 4'h1;
   end
endmodule
`default_nettype wire

/* tpi_pkg.sv */
// Shared constants and types for the timer prescaler and interrupt flag block.
`default_nettype none
package tpi_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [1:0] ADDR_IRQ_FLAGS     = 2'h0;
   localparam logic [1:0] ADDR_IRQ_MASK      = 2'h1;
   localparam logic [1:0] ADDR_GENERAL_CTRL  = 2'h2;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int FLAG_T8_CMP_A    = 0;
   localparam int FLAG_T8_OVF      = 1;
   localparam int FLAG_T8_CMP_B    = 2;
   localparam int FLAG_T16_CAPTURE = 3;
   localparam int FLAG_RESERVED    = 4;
   localparam int FLAG_T16_CMP_B   = 5;
   localparam int FLAG_T16_CMP_A   = 6;
   localparam int FLAG_T16_OVF     = 7;
   localparam int PRESCALER_RESET_BIT = 0;

   // ****************************************
   // Reset values and masks
   // ****************************************
   localparam logic [7:0] IRQ_FLAGS_RESET = 8'h00;
   localparam logic [7:0] IRQ_MASK_RESET  = 8'h00;
   localparam logic [7:0] RESERVED_MASK   = 8'hEF;
   localparam logic [7:0] COUNT_MAX       = 8'hFF;
   localparam logic [7:0] COUNT_BOTTOM    = 8'h00;

   // ****************************************
   // Prescaler
   // ****************************************
   localparam int          PRESCALER_WIDTH = 10;
   localparam logic [9:0]  PRESCALER_RESET = 10'h000;
   localparam logic [9:0]  TAP_DIV8_MASK    = 10'h007;
   localparam logic [9:0]  TAP_DIV64_MASK   = 10'h03F;
   localparam logic [9:0]  TAP_DIV256_MASK  = 10'h0FF;
   localparam logic [9:0]  TAP_DIV1024_MASK = 10'h3FF;

   // ****************************************
   // Clock select and waveform mode codes
   // ****************************************
   localparam logic [2:0] CS_STOPPED  = 3'h0;
   localparam logic [2:0] CS_DIRECT   = 3'h1;
   localparam logic [2:0] CS_DIV8     = 3'h2;
   localparam logic [2:0] CS_DIV64    = 3'h3;
   localparam logic [2:0] CS_DIV256   = 3'h4;
   localparam logic [2:0] CS_DIV1024  = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;

   localparam logic [2:0] WGM_NORMAL       = 3'h0;
   localparam logic [2:0] WGM_PC_FIXED     = 3'h1;
   localparam logic [2:0] WGM_CTC          = 3'h2;
   localparam logic [2:0] WGM_FAST_FIXED   = 3'h3;
   localparam logic [2:0] WGM_PC_PROG      = 3'h5;
   localparam logic [2:0] WGM_FAST_PROG    = 3'h7;

   // ****************************************
   // Register port request
   // ****************************************
   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } tpi_bus_req_t;

   // Events reported by the 16-bit timer, one-cycle pulses.
   typedef struct packed {
      logic ovf;
      logic cmp_a;
      logic cmp_b;
      logic capture;
   } tpi_t16_events_t;

endpackage
`default_nettype wire

/* tpi_top.sv */
// Shared timer prescaler, external clock pin sampling and timer interrupt flags.
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module tpi_top
(
   input  wire logic                    i_clk,
   input  wire logic                    i_resetn,
   input  wire logic                    i_ce,
   input  wire tpi_pkg::tpi_bus_req_t   i_bus,
   output var  logic [7:0]              o_rdata,
   input  wire logic [2:0]              i_t8_clock_select_field,
   input  wire logic [2:0]              i_t16_clock_select_field,
   input  wire logic [1:0]              i_ext_timer_clock_pins,
   input  wire logic [2:0]              i_waveform_mode_field,
   input  wire logic [7:0]              i_t8_count,
   input  wire logic [7:0]              i_t8_compare_a_value,
   input  wire logic [7:0]              i_t8_compare_b_value,
   input  wire tpi_pkg::tpi_t16_events_t i_t16_events,
   input  wire logic                    i_global_irq_en,
   input  wire logic [2:0]              i_irq_ack,
   output var  logic                    o_t8_count_pulse,
   output var  logic                    o_t16_count_pulse,
   output var  logic [2:0]              o_irq_req
);

   // ****************************************
   // Declarations
   // ****************************************
   logic [tpi_pkg::PRESCALER_WIDTH-1:0] prescaler;
   logic                                prescaler_reset_strobe;
   logic [7:0]                          timer_irq_flags;
   logic [7:0]                          timer_irq_mask;
   logic [1:0]                          pin_latch;
   logic [1:0]                          pin_sync;
   logic [1:0]                          pin_prev;
   logic [1:0]                          pin_rise;
   logic [1:0]                          pin_fall;
   logic [3:0]                          taps;
   logic                                wr_flags;
   logic [7:0]                          flag_set;
   logic [7:0]                          flag_clr;
   logic [7:0]                          next_flags;
   logic [7:0]                          next_mask;
   logic                                wr_mask;
   logic                                t8_ovf_point;

   // Picks the count pulse of one timer from its clock select field.
   function automatic logic select_tick(input logic [2:0] cs, input logic [3:0] tap,
                                        input logic rise, input logic fall);
      logic t;
      t = 1'b0;
      case (cs)
         tpi_pkg::CS_STOPPED:  t = 1'b0;
         tpi_pkg::CS_DIRECT:   t = 1'b1;
         tpi_pkg::CS_DIV8:     t = tap[0];
         tpi_pkg::CS_DIV64:    t = tap[1];
         tpi_pkg::CS_DIV256:   t = tap[2];
         tpi_pkg::CS_DIV1024:  t = tap[3];
         tpi_pkg::CS_EXT_FALL: t = fall;
         tpi_pkg::CS_EXT_RISE: t = rise;
         default:              t = 1'b0;
      endcase
      return t;
   endfunction

   // True when the request writes the register at the given address.
   function automatic logic bus_write_hit(input tpi_pkg::tpi_bus_req_t req,
                                          input logic [1:0]            addr);
      return req.wr && (req.addr == addr);
   endfunction

   // True on the one prescaler state in each period whose masked low bits are all ones.
   function automatic logic tap_hit(input logic [tpi_pkg::PRESCALER_WIDTH-1:0] count,
                                    input logic [tpi_pkg::PRESCALER_WIDTH-1:0] mask);
      return (count & mask) == mask;
   endfunction

   // ****************************************
   // Shared prescaler
   // ****************************************

   // Free-running divider, restarted only by the prescaler reset strobe.
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         prescaler <= tpi_pkg::PRESCALER_RESET;
      end
      else if (i_ce)
      begin
         if (prescaler_reset_strobe)
         begin
            prescaler <= tpi_pkg::PRESCALER_RESET;
         end
         else
         begin
            prescaler <= prescaler + 10'h001;
         end
      end
   end

   // Each tap fires once per period when its low bits are all ones.
   // A restart of the divider delays every tap, so both timers see the same new phase.
   assign taps[0] = tap_hit(prescaler, tpi_pkg::TAP_DIV8_MASK);
   assign taps[1] = tap_hit(prescaler, tpi_pkg::TAP_DIV64_MASK);
   assign taps[2] = tap_hit(prescaler, tpi_pkg::TAP_DIV256_MASK);
   assign taps[3] = tap_hit(prescaler, tpi_pkg::TAP_DIV1024_MASK);

   // The reset bit is a strobe that hardware drops again after one cycle.
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         prescaler_reset_strobe <= 1'b0;
      end
      else if (i_ce)
      begin
         prescaler_reset_strobe <= bus_write_hit(i_bus, tpi_pkg::ADDR_GENERAL_CTRL)
                                   && i_bus.wdata[tpi_pkg::PRESCALER_RESET_BIT];
      end
   end

   // ****************************************
   // External clock pin sampling
   // ****************************************

   // Latch open while the clock is high; it carries no reset.
   // Taking the pin in the high phase gains half a cycle, which is what puts the
   // pin-to-count delay between two and a half and three and a half clocks.
   always_latch
   begin
      if (i_clk)
      begin
         pin_latch = i_ext_timer_clock_pins;
      end
   end

   // Rising-edge registers behind the latch, then the edge history.
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         pin_sync <= 2'h0;
         pin_prev <= 2'h0;
      end
      else if (i_ce)
      begin
         pin_sync <= pin_latch;
         pin_prev <= pin_sync;
      end
   end

   // Edge detection on the synchronised pins, bit 0 for the 8-bit timer.
   assign pin_rise = pin_sync & ~pin_prev;
   assign pin_fall = ~pin_sync & pin_prev;

   // ****************************************
   // Timer count pulses
   // ****************************************

   // Count pulse of the 8-bit timer, from the shared taps and pin 0.
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         o_t8_count_pulse <= 1'b0;
      end
      else if (i_ce)
      begin
         o_t8_count_pulse <= select_tick(i_t8_clock_select_field, taps,
                                         pin_rise[0], pin_fall[0]);
      end
   end

   // Count pulse of the 16-bit timer, from the same taps and pin 1.
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         o_t16_count_pulse <= 1'b0;
      end
      else if (i_ce)
      begin
         o_t16_count_pulse <= select_tick(i_t16_clock_select_field, taps,
                                          pin_rise[1], pin_fall[1]);
      end
   end

   // ****************************************
   // Interrupt flags
   // ****************************************

   // Overflow point of the 8-bit counter for the selected waveform mode.
   always_comb
   begin
      case (i_waveform_mode_field)
         tpi_pkg::WGM_NORMAL,
         tpi_pkg::WGM_CTC,
         tpi_pkg::WGM_FAST_FIXED: t8_ovf_point = i_t8_count == tpi_pkg::COUNT_MAX;
         tpi_pkg::WGM_PC_FIXED,
         tpi_pkg::WGM_PC_PROG:    t8_ovf_point = i_t8_count == tpi_pkg::COUNT_BOTTOM;
         tpi_pkg::WGM_FAST_PROG:  t8_ovf_point = i_t8_count == i_t8_compare_a_value;
         default:                 t8_ovf_point = 1'b0;
      endcase
   end

   // Hardware set events; the 8-bit ones count on a timer clock pulse.
   always_comb
   begin
      flag_set = 8'h00;
      flag_set[tpi_pkg::FLAG_T8_CMP_A] = o_t8_count_pulse
                                         && (i_t8_count == i_t8_compare_a_value);
      flag_set[tpi_pkg::FLAG_T8_OVF]   = o_t8_count_pulse && t8_ovf_point;
      flag_set[tpi_pkg::FLAG_T8_CMP_B] = o_t8_count_pulse
                                         && (i_t8_count == i_t8_compare_b_value);
      flag_set[tpi_pkg::FLAG_T16_CAPTURE] = i_t16_events.capture;
      flag_set[tpi_pkg::FLAG_T16_CMP_B]   = i_t16_events.cmp_b;
      flag_set[tpi_pkg::FLAG_T16_CMP_A]   = i_t16_events.cmp_a;
      flag_set[tpi_pkg::FLAG_T16_OVF]     = i_t16_events.ovf;
   end

   // Clears from write-one and from vector acknowledge; a set in the same cycle wins.
   // A clear that meets a set in one cycle loses, so no event that arrives while the clock enable is high is dropped.
   assign wr_flags = bus_write_hit(i_bus, tpi_pkg::ADDR_IRQ_FLAGS);

   always_comb
   begin
      flag_clr = wr_flags ? i_bus.wdata : 8'h00;
      flag_clr[tpi_pkg::FLAG_T8_CMP_A] = flag_clr[tpi_pkg::FLAG_T8_CMP_A] | i_irq_ack[0];
      flag_clr[tpi_pkg::FLAG_T8_OVF]   = flag_clr[tpi_pkg::FLAG_T8_OVF] | i_irq_ack[1];
      flag_clr[tpi_pkg::FLAG_T8_CMP_B] = flag_clr[tpi_pkg::FLAG_T8_CMP_B] | i_irq_ack[2];
      next_flags = ((timer_irq_flags & ~flag_clr) | flag_set) & tpi_pkg::RESERVED_MASK;
   end

   // Flag register.
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         timer_irq_flags <= tpi_pkg::IRQ_FLAGS_RESET;
      end
      else if (i_ce)
      begin
         timer_irq_flags <= next_flags;
      end
   end

   // Next mask value; the reserved bit is never stored.
   assign wr_mask = bus_write_hit(i_bus, tpi_pkg::ADDR_IRQ_MASK);

   always_comb
   begin
      next_mask = timer_irq_mask;
      if (wr_mask)
      begin
         next_mask = i_bus.wdata & tpi_pkg::RESERVED_MASK;
      end
   end

   // Mask register.
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         timer_irq_mask <= tpi_pkg::IRQ_MASK_RESET;
      end
      else if (i_ce)
      begin
         timer_irq_mask <= next_mask;
      end
   end

   // Level requests, one per 8-bit vector, gated by enable and global enable.
   // They follow the next mask and flags, so a cleared enable or flag drops the
   // request at the same edge instead of leaving it up for one stale cycle.
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         o_irq_req <= 3'h0;
      end
      else if (i_ce)
      begin
         o_irq_req[0] <= i_global_irq_en && next_mask[tpi_pkg::FLAG_T8_CMP_A]
                         && next_flags[tpi_pkg::FLAG_T8_CMP_A];
         o_irq_req[1] <= i_global_irq_en && next_mask[tpi_pkg::FLAG_T8_OVF]
                         && next_flags[tpi_pkg::FLAG_T8_OVF];
         o_irq_req[2] <= i_global_irq_en && next_mask[tpi_pkg::FLAG_T8_CMP_B]
                         && next_flags[tpi_pkg::FLAG_T8_CMP_B];
      end
   end

   // ****************************************
   // Register read port
   // ****************************************

   // Read data stand for one cycle after the strobe, zero otherwise.
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         o_rdata <= 8'h00;
      end
      else if (i_ce)
      begin
         o_rdata <= 8'h00;
         if (i_bus.rd)
         begin
            case (i_bus.addr)
               tpi_pkg::ADDR_IRQ_FLAGS:    o_rdata <= timer_irq_flags;
               tpi_pkg::ADDR_IRQ_MASK:     o_rdata <= timer_irq_mask;
               tpi_pkg::ADDR_GENERAL_CTRL: o_rdata <= 8'h00;
               default:                    o_rdata <= 8'h00;
            endcase
         end
      end
   end

endmodule
`default_nettype wire
